// ---- common/psg_pkg.sv ----
/*
 * package for the power-save clock gating block: register offsets, field
 * positions, reset values, power-state encodings and timing counts.
 * assumes a single 200 MHz system clock domain.
 */
package psg_pkg;

    // ========================================================================
    // register map (16-bit registers on a plain strobe port)
    // ========================================================================
    localparam logic [3:0] ADDR_CLOCK_DIVIDER_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CLOCK_SOURCE_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_MODULE_DISABLE_BITS = 4'h2;
    localparam logic [3:0] ADDR_POWER_STATUS = 4'h3;

    // clock_divider_control fields
    localparam int RATIO_LSB = 12;
    localparam int RATIO_MSB = 14;
    localparam int SLOWDOWN_BIT = 11;
    localparam int RECOVER_BIT = 15;
    localparam logic [2:0] RATIO_RESET = 3'h0;

    // clock_source_control fields
    localparam int NEXT_SEL_LSB = 8;
    localparam int NEXT_SEL_MSB = 10;
    localparam int CUR_SEL_LSB = 12;
    localparam int CUR_SEL_MSB = 14;
    localparam int SWITCH_REQ_BIT = 0;
    localparam logic [2:0] CLOCK_SEL_RESET = 3'h0;

    // power-save instruction argument
    localparam logic SAVE_ARG_SLEEP = 1'b0;
    localparam logic SAVE_ARG_IDLE = 1'b1;

    // module_disable_bits reset value: all present modules enabled
    localparam logic [15:0] MODULE_DISABLE_RESET = 16'h0000;

    // ========================================================================
    // timing
    // ========================================================================
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESUME_MIN_CYCLES = 2;
    localparam int RESUME_MAX_CYCLES = 4;
    localparam int RESUME_CYCLES = 3;
    localparam int DISABLE_DELAY_CYCLES = 1;

    typedef enum logic [3:0] {
        PSG_RUN = 4'b0001,
        PSG_SLEEP = 4'b0010,
        PSG_IDLE = 4'b0100,
        PSG_RESUME = 4'b1000
    } psg_state_e;

endpackage

// ---- core/psg_glitch_gate.sv ----
/*
 * glitch-free clock gate: latch on the low phase, and with the clock.
 * assumes the enable changes synchronously to the rising edge of clk_in.
 */
`timescale 1ns/1ps
module psg_glitch_gate (
    input wire logic clk_in,
    input wire logic enable,
    output logic clk_out
);

    // ========================================================================
    // low-phase latch so the gate only changes while the clock is low
    // ========================================================================
    logic en_latched;

    always_latch begin
        if (!clk_in) begin
            en_latched <= enable;
        end
    end

    assign clk_out = clk_in & en_latched;

endmodule

// ---- core/psg_power_ctrl.sv ----
/*
 * power-save clock gating: sleep and idle entry and wake, cpu slowdown
 * divider, per-module clock disable, clock source hold across sleep.
 * assumes a cpu that pulses save_exec on the power-save instruction and
 * peripherals that accept a clock plus a one-bit enable each.
 */
`timescale 1ns/1ps
module psg_power_ctrl #(
    parameter int NUM_MODULES = 16,
    parameter logic [15:0] MODULE_PRESENT = 16'hFFFF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic save_exec,
    input wire logic save_arg,
    input wire logic irq_pending,
    input wire logic wdt_timeout,
    input wire logic wdt_enabled,
    input wire logic fail_mon_enabled,
    input wire logic switch_enabled,
    input wire logic high_byte_unlocked,
    input wire logic src_switch_done,
    output logic cpu_clk,
    output logic periph_clk,
    output logic cpu_run,
    output logic cpu_tick,
    output logic wdt_clear,
    output logic sys_osc_enable,
    output logic low_power_rc_clock_enable,
    output logic fail_mon_active,
    output logic [2:0] clock_source_sel,
    output logic [15:0] module_clk_enable,
    output logic [15:0] module_reg_valid
);

    // ========================================================================
    // registers
    // ========================================================================
    // power state and wake bookkeeping
    psg_pkg::psg_state_e state;
    logic [2:0] resume_cnt;
    logic irq_deferred;
    // software-visible divider fields
    logic slowdown_en;
    logic recover_on_irq;
    logic [2:0] ratio;
    // clock source selection
    logic [2:0] next_clock_select;
    logic [2:0] current_clock_select;
    logic switch_req;
    // module disable, as written and as applied
    logic [15:0] module_disable_bits;
    logic [15:0] module_disable_applied;
    // divider and gate enables
    logic [6:0] div_cnt;
    logic [6:0] div_limit;
    logic div_tick;
    logic cpu_gate_en;
    logic periph_gate_en;
    logic wake_event;

    // wake sources common to sleep and idle; the deferred flag turns an
    // interrupt seen with the instruction into a wake right after entry
    assign wake_event = irq_pending | wdt_timeout | irq_deferred;

    // ========================================================================
    // power state machine
    // ========================================================================
    // enters sleep or idle on the instruction, leaves on a wake event
    // sleep returns straight to run; idle passes through resume so the
    // cpu restarts a fixed number of cycles after its clock comes back
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= psg_pkg::PSG_RUN;
        end else begin
            unique case (state)
                psg_pkg::PSG_RUN: begin
                    if (save_exec) begin
                        if (save_arg == psg_pkg::SAVE_ARG_SLEEP) begin
                            state <= psg_pkg::PSG_SLEEP;
                        end else begin
                            state <= psg_pkg::PSG_IDLE;
                        end
                    end
                end
                psg_pkg::PSG_SLEEP: begin
                    if (wake_event) begin
                        state <= psg_pkg::PSG_RUN;
                    end
                end
                psg_pkg::PSG_IDLE: begin
                    if (wake_event) begin
                        state <= psg_pkg::PSG_RESUME;
                    end
                end
                psg_pkg::PSG_RESUME: begin
                    if (resume_cnt == 3'(psg_pkg::RESUME_CYCLES - 1)) begin
                        state <= psg_pkg::PSG_RUN;
                    end
                end
            endcase
        end
    end

    // interrupt coincident with the instruction waits until entry completes
    // set only in run and cleared only outside it, so set and clear
    // can never fall in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_deferred <= 1'b0;
        end else if (state == psg_pkg::PSG_RUN && save_exec && irq_pending) begin
            irq_deferred <= 1'b1;
        end else if (state != psg_pkg::PSG_RUN) begin
            irq_deferred <= 1'b0; // consumed by the immediate wake
        end
    end

    // cycles between clock reapplied and first instruction after idle
    // counts while in resume and rests at zero everywhere else
    // reaching the last count releases the cpu on the next edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            resume_cnt <= 3'h0;
        end else if (state == psg_pkg::PSG_RESUME) begin
            resume_cnt <= resume_cnt + 3'h1;
        end else begin
            resume_cnt <= 3'h0;
        end
    end

    // watchdog clear pulse on sleep or idle entry
    // one cycle long, launched by the same edge that enters the state
    // and only when the watchdog runs, since a stopped one needs no clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wdt_clear <= 1'b0;
        end else begin
            wdt_clear <= state == psg_pkg::PSG_RUN && save_exec && wdt_enabled;
        end
    end

    // ========================================================================
    // register writes
    // ========================================================================
    // clock divider control; a write in the same cycle as an interrupt
    // wins over the recover clear, and recover leaves ratio untouched
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            slowdown_en <= 1'b0;
            recover_on_irq <= 1'b0;
            ratio <= psg_pkg::RATIO_RESET;
        end else if (reg_write && reg_addr == psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL) begin
            slowdown_en <= reg_wdata[psg_pkg::SLOWDOWN_BIT];
            recover_on_irq <= reg_wdata[psg_pkg::RECOVER_BIT];
            ratio <= reg_wdata[psg_pkg::RATIO_MSB:psg_pkg::RATIO_LSB];
        end else if (recover_on_irq && irq_pending && slowdown_en) begin
            slowdown_en <= 1'b0;
        end
    end

    // next clock select, honoured only when switching allowed and unlocked
    // the request bit sits outside the guarded high byte, so it is taken
    // even while the next-select field is locked
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            next_clock_select <= psg_pkg::CLOCK_SEL_RESET;
            switch_req <= 1'b0;
        end else if (reg_write && reg_addr == psg_pkg::ADDR_CLOCK_SOURCE_CONTROL && switch_enabled) begin
            if (high_byte_unlocked) begin
                next_clock_select <= reg_wdata[psg_pkg::NEXT_SEL_MSB:psg_pkg::NEXT_SEL_LSB];
            end
            switch_req <= reg_wdata[psg_pkg::SWITCH_REQ_BIT];
        end else if (src_switch_done) begin
            switch_req <= 1'b0;
        end
    end

    // current source only changes on a completed switch, whatever the power state
    // sleep leaves it alone, so a wake resumes on the source it left
    // the oscillator logic reports completion, this block only records it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            current_clock_select <= psg_pkg::CLOCK_SEL_RESET;
        end else if (switch_req && src_switch_done) begin
            current_clock_select <= next_clock_select;
        end
    end
    assign clock_source_sel = current_clock_select;

    // module disable bits; absent modules read as disabled
    // absent modules stay off whatever software writes here
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            module_disable_bits <= psg_pkg::MODULE_DISABLE_RESET;
        end else if (reg_write && reg_addr == psg_pkg::ADDR_MODULE_DISABLE_BITS) begin
            module_disable_bits <= reg_wdata;
        end
    end

    // one instruction cycle of delay before a change reaches the module
    // the copy steps on a cpu tick, so under slowdown the delay stretches
    // to one divided cpu cycle rather than one system cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            module_disable_applied <= psg_pkg::MODULE_DISABLE_RESET;
        end else if (cpu_tick) begin
            module_disable_applied <= module_disable_bits;
        end
    end

    // ========================================================================
    // read port: data one cycle after the strobe
    // ========================================================================
    // data read zero outside the answer cycle, so a stale word is never
    // mistaken for a fresh read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL: begin
                    reg_rdata <= {recover_on_irq, ratio, slowdown_en, 11'h000};
                end
                psg_pkg::ADDR_CLOCK_SOURCE_CONTROL: begin
                    reg_rdata <= {1'b0, current_clock_select, 1'b0, next_clock_select, 7'h00, switch_req};
                end
                psg_pkg::ADDR_MODULE_DISABLE_BITS: begin
                    reg_rdata <= module_disable_bits | ~MODULE_PRESENT;
                end
                psg_pkg::ADDR_POWER_STATUS: begin
                    reg_rdata <= {12'h000, state};
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ========================================================================
    // cpu slowdown divider
    // ========================================================================
    // ratio n gives a limit of 2^n - 1, so 2^n system cycles per cpu tick
    // a zero limit when slowdown is off gives a tick every cycle
    // the 8-bit shift keeps 2^7 from overflowing before the subtraction
    always_comb begin
        div_limit = 7'h00;
        if (slowdown_en) begin
            div_limit = 7'((8'h01 << ratio) - 8'h01);
        end
    end

    // counter runs on the system clock so both domains share edges
    // the >= compare restarts the count when a smaller ratio is written
    // mid-count, so the cpu never waits out a stale long period
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            div_cnt <= 7'h00;
        end else if (div_cnt >= div_limit) begin
            div_cnt <= 7'h00;
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end
    assign div_tick = div_cnt >= div_limit;

    // ========================================================================
    // clock gates and power outputs
    // ========================================================================
    // the cpu gate opens only on a tick, so halt, idle and division all
    // come down to one enable; peripherals stop only in sleep
    // the watchdog holds the rc clock in every state, the monitor only
    // outside sleep
    assign cpu_run = state == psg_pkg::PSG_RUN;
    assign cpu_tick = cpu_run & div_tick;
    assign cpu_gate_en = cpu_tick;
    assign periph_gate_en = state != psg_pkg::PSG_SLEEP;
    assign sys_osc_enable = state != psg_pkg::PSG_SLEEP;
    assign fail_mon_active = fail_mon_enabled & (state != psg_pkg::PSG_SLEEP);
    assign low_power_rc_clock_enable = wdt_enabled | (fail_mon_enabled & (state != psg_pkg::PSG_SLEEP));

    // cpu clock, gated per tick
    psg_glitch_gate u_cpu_gate (
        .clk_in(clk_sys),
        .enable(cpu_gate_en),
        .clk_out(cpu_clk)
    );

    // peripheral clock, off only in sleep
    psg_glitch_gate u_periph_gate (
        .clk_in(clk_sys),
        .enable(periph_gate_en),
        .clk_out(periph_clk)
    );

    // per-module clock enable and register access valid
    // a module clock runs only when present, enabled and not in sleep;
    // register access follows presence and the disable bit, not sleep
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MODULES; gi++) begin : g_mod
            assign module_clk_enable[gi] = MODULE_PRESENT[gi] & ~module_disable_applied[gi]
                & periph_gate_en;
            assign module_reg_valid[gi] = MODULE_PRESENT[gi] & ~module_disable_applied[gi];
        end
    endgenerate

endmodule

// ---- sim/psg_cpu_model.sv ----
/*
 * cpu and peripheral stand-in: issues the power-save instruction and
 * counts edges of the gated cpu and peripheral clocks.
 * assumes the bench raises save_req for one cycle.
 */
`timescale 1ns/1ps
module psg_cpu_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cpu_clk,
    input wire logic periph_clk,
    input wire logic cpu_tick,
    input wire logic save_req,
    input wire logic save_mode,
    output logic save_exec,
    output logic save_arg,
    output int cpu_edges,
    output int periph_edges
);
    // ========================================================================
    // instruction issue and clock counting
    initial begin
        save_exec = 1'b0;
        save_arg = 1'b0;
        cpu_edges = 0;
        periph_edges = 0;
    end
    // the instruction only issues on a cycle the cpu executes
    always @(posedge clk_sys) begin
        save_exec <= rst_n && save_req && cpu_tick;
        save_arg <= save_mode;
    end
    // edge counts let the bench see halted or divided clocks
    always @(posedge cpu_clk) cpu_edges++;
    always @(posedge periph_clk) periph_edges++;
endmodule

// ---- sim/psg_power_ctrl_asserts.sv ----
/*
 * checker for psg_power_ctrl: power-state entry, wake and clock relations.
 * assumes it is bound to the top module ports, one clock domain.
 */
`timescale 1ns/1ps
module psg_power_ctrl_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic save_exec,
    input wire logic save_arg,
    input wire logic irq_pending,
    input wire logic wdt_timeout,
    input wire logic wdt_enabled,
    input wire logic fail_mon_enabled,
    input wire logic cpu_run,
    input wire logic cpu_tick,
    input wire logic wdt_clear,
    input wire logic sys_osc_enable,
    input wire logic low_power_rc_clock_enable,
    input wire logic fail_mon_active,
    input wire logic [2:0] clock_source_sel
);
    // ========================================================================
    // power-state relations
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // power-save instruction accepted on an executed cycle
    sequence save_taken(a);
        cpu_tick && save_exec && save_arg == a;
    endsequence
    // cpu held off, then back within the resume window
    sequence resume_wait;
        !cpu_run ##[1:5] cpu_run;
    endsequence
    wdt_clear_a: assert property (cpu_tick && save_exec && wdt_enabled |=> wdt_clear)
        else $error("watchdog not cleared on power save");
    sleep_entry_a: assert property (save_taken(psg_pkg::SAVE_ARG_SLEEP) |=>
        !sys_osc_enable && !cpu_run && !fail_mon_active)
        else $error("sleep entry wrong");
    idle_entry_a: assert property (save_taken(psg_pkg::SAVE_ARG_IDLE) |=>
        sys_osc_enable && !cpu_run)
        else $error("idle entry wrong");
    sleep_low_power_rc_clock_a: assert property (!sys_osc_enable && wdt_enabled |-> low_power_rc_clock_enable)
        else $error("rc clock off in sleep");
    idle_low_power_rc_clock_a: assert property (sys_osc_enable && (wdt_enabled || fail_mon_enabled) |-> low_power_rc_clock_enable)
        else $error("rc clock off while needed");
    sleep_wake_a: assert property (!sys_osc_enable && (irq_pending || wdt_timeout) |=> cpu_run)
        else $error("no wake from sleep");
    idle_wake_a: assert property (save_taken(psg_pkg::SAVE_ARG_IDLE) ##0 irq_pending |=> resume_wait)
        else $error("idle wake timing wrong");
    source_hold_a: assert property (!sys_osc_enable |-> $stable(clock_source_sel))
        else $error("clock source changed in sleep");
    tick_gate_a: assert property (!cpu_run |-> !cpu_tick)
        else $error("cpu executes while halted");
endmodule

bind psg_power_ctrl psg_power_ctrl_asserts u_chk (.clk_sys, .rst_n, .save_exec, .save_arg, .irq_pending,
    .wdt_timeout, .wdt_enabled, .fail_mon_enabled, .cpu_run, .cpu_tick, .wdt_clear, .sys_osc_enable,
    .low_power_rc_clock_enable, .fail_mon_active, .clock_source_sel);

// ---- sim/tb_psg_power_ctrl.sv ----
/*
 * self-checking bench for psg_power_ctrl: registers, sleep, idle, slowdown,
 * module disable and source selection.
 * assumes the cpu model in psg_cpu_model and a 200 MHz clock.
 */
`timescale 1ns/1ps
module tb_psg_power_ctrl;
    logic clk_sys, rst_n, reg_write, reg_read, save_exec, save_arg, irq_pending, wdt_timeout;
    logic wdt_enabled, fail_mon_enabled, switch_enabled, high_byte_unlocked, src_switch_done;
    logic cpu_clk, periph_clk, cpu_run, cpu_tick, wdt_clear, sys_osc_enable, low_power_rc_clock_enable, fail_mon_active;
    logic save_req, save_mode;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, module_clk_enable, module_reg_valid;
    logic [2:0] clock_source_sel;
    int cpu_edges, periph_edges, err_total, cmp_count;

    psg_power_ctrl u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .save_exec, .save_arg, .irq_pending, .wdt_timeout, .wdt_enabled, .fail_mon_enabled, .switch_enabled,
        .high_byte_unlocked, .src_switch_done, .cpu_clk, .periph_clk, .cpu_run, .cpu_tick, .wdt_clear,
        .sys_osc_enable, .low_power_rc_clock_enable, .fail_mon_active, .clock_source_sel, .module_clk_enable, .module_reg_valid);
    psg_cpu_model u_cpu (.clk_sys, .rst_n, .cpu_clk, .periph_clk, .cpu_tick, .save_req, .save_mode,
        .save_exec, .save_arg, .cpu_edges, .periph_edges);

    // ========================================================================
    // helpers
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task irq_pulse;
        @(posedge clk_sys);
        irq_pending <= 1'b1;
        @(posedge clk_sys);
        irq_pending <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task end_of_test;
        $display("mismatches %0d of %0d compares", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ========================================================================
    // scenarios
    // reset values and an unmapped read
    task t_reset;
        logic [15:0] r;
        rd(psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL, r);
        chk("div_ctrl", 16'h0000, r);
        rd(psg_pkg::ADDR_MODULE_DISABLE_BITS, r);
        chk("mod_dis", psg_pkg::MODULE_DISABLE_RESET, r);
        rd(4'hF, r);
        chk("unmapped", 16'h0000, r);
        chk("mod_en", 16'hFFFF, module_clk_enable);
    endtask
    // every ratio, then ratio with slowdown off, then recover on interrupt
    task t_doze;
        int t, c, p;
        logic [15:0] r;
        for (int n = 0; n < 9; n++) begin
            wr(psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL, n < 8 ? 16'(16'h0800 | (n << 12)) : 16'h7000);
            repeat (4) @(posedge clk_sys);
            #1 t = 0;
            c = cpu_edges;
            p = periph_edges;
            repeat (256) begin
                @(posedge clk_sys);
                #1 if (cpu_tick === 1'b1) t++;
            end
            chk("cpu_ticks", 16'(n < 8 ? 256 >> n : 256), 16'(t));
            chk("cpu_edges", 16'(t), 16'(cpu_edges - c));
            chk("periph_edges", 16'h0100, 16'(periph_edges - p));
        end
        wr(psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL, 16'hB800);
        irq_pulse;
        rd(psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL, r);
        chk("recover_on", 16'hB000, r);
        wr(psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL, 16'h3800);
        irq_pulse;
        rd(psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL, r);
        chk("recover_off", 16'h3800, r);
        wr(psg_pkg::ADDR_CLOCK_DIVIDER_CONTROL, 16'h0000);
    endtask
    // disable some modules, then enable them again
    task t_module;
        logic [15:0] r;
        wr(psg_pkg::ADDR_MODULE_DISABLE_BITS, 16'h00A5);
        #1 chk("en_before", 16'hFFFF, module_clk_enable);
        @(posedge clk_sys);
        #1 chk("en_after", 16'hFF5A, module_clk_enable);
        chk("reg_valid", 16'hFF5A, module_reg_valid);
        rd(psg_pkg::ADDR_MODULE_DISABLE_BITS, r);
        chk("mod_rd", 16'h00A5, r);
        wr(psg_pkg::ADDR_MODULE_DISABLE_BITS, 16'h0000);
        @(posedge clk_sys);
        #1 chk("re_enable", 16'hFFFF, module_clk_enable);
    endtask
    // locked write is kept out, unlocked write switches the source
    task t_source;
        logic [15:0] r;
        @(posedge clk_sys);
        switch_enabled <= 1'b1;
        wr(psg_pkg::ADDR_CLOCK_SOURCE_CONTROL, 16'h0301);
        rd(psg_pkg::ADDR_CLOCK_SOURCE_CONTROL, r);
        chk("next_locked", 16'h0000, r & 16'h0700);
        @(posedge clk_sys);
        high_byte_unlocked <= 1'b1;
        wr(psg_pkg::ADDR_CLOCK_SOURCE_CONTROL, 16'h0501);
        @(posedge clk_sys);
        src_switch_done <= 1'b1;
        @(posedge clk_sys);
        src_switch_done <= 1'b0;
        #1 chk("sel_new", 16'h0005, 16'(clock_source_sel));
    endtask
    // enter sleep or idle, wake by interrupt or watchdog, or coincident interrupt
    task t_save(input logic arg, input logic wk, input logic co);
        logic [2:0] s;
        logic ok;
        int p, c, n;
        s = clock_source_sel;
        @(posedge clk_sys);
        save_req <= 1'b1;
        save_mode <= arg;
        irq_pending <= co;
        @(posedge clk_sys);
        save_req <= 1'b0;
        @(posedge clk_sys);
        #1 chk("wdt_clear", 16'h0001, 16'(wdt_clear));
        chk("cpu_tick", 16'h0000, 16'(cpu_tick));
        chk("osc_en", 16'(arg), 16'(sys_osc_enable));
        chk("low_power_rc_clock", 16'h0001, 16'(low_power_rc_clock_enable));
        chk("mod_clk", arg ? 16'hFFFF : 16'h0000, module_clk_enable);
        if (!arg) chk("fail_mon", 16'h0000, 16'(fail_mon_active));
        if (!co) begin
            p = periph_edges;
            c = cpu_edges;
            repeat (4) @(posedge clk_sys);
            #1 chk("periph_run", arg ? 16'h0004 : 16'h0000, 16'(periph_edges - p));
            chk("cpu_halt", 16'h0000, 16'(cpu_edges - c));
            @(posedge clk_sys);
            if (wk) wdt_timeout <= 1'b1;
            else irq_pending <= 1'b1;
        end
        n = 0;
        while (cpu_run !== 1'b1 && n < 12) begin
            @(posedge clk_sys);
            #1 n++;
        end
        ok = n > psg_pkg::RESUME_MIN_CYCLES && n <= psg_pkg::RESUME_MAX_CYCLES + 1;
        if (arg) chk("idle_wake", 16'h0001, 16'(ok));
        else chk("sleep_wake", 16'h0001, 16'(n));
        chk("src_kept", 16'(s), 16'(clock_source_sel));
        @(posedge clk_sys);
        irq_pending <= 1'b0;
        wdt_timeout <= 1'b0;
    endtask

    // ========================================================================
    // clock, watchdog and main sequence
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        err_total++;
        end_of_test;
    end
    initial begin
        {rst_n, reg_write, reg_read, irq_pending, wdt_timeout, switch_enabled} = '0;
        {high_byte_unlocked, src_switch_done, save_req, save_mode} = '0;
        {wdt_enabled, fail_mon_enabled} = 2'b11;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        err_total = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_doze;
        t_module;
        t_source;
        for (int i = 0; i < 6; i++) t_save(1'(i), 1'(i >> 1), 1'(i >> 2));
        end_of_test;
    end
endmodule
